// *** core/bsf_regs.sv ***
// board special function registers: flash page, user, watchdog, routing
`timescale 1ns/1ps
`include "bsf_cfg.svh"
// Notes on behaviour
// - high flash page bits 8..4, reset zero
// - low flash page bits 3..0, irq gate
// - serial memory lines driven when bit set
// - user straps readable at bits 4, 5
// - led bit lights indicator, reset zero
// - status read clears time-out flag
// - status shows time-out seen, watchdog active
// - status upper bits reflect link straps
// - watchdog off until 33h then CCh
// - kick 55h AAh within one second
// - 33h then 99h remaps boot rom
// - 55h then 66h disengages watchdog
// - watchdog reset drives backplane reset if strapped
// - backplane config routes attention requests
// - redirect blocks atn1; atn7 replaces mouse
// - broadcast bit drives transfer error line
// - period bits pick 16, 8, 4 us, off
// - unanswered backplane transfer gets terminated
// - peripheral register routes on-board serial, printer
// - serial one route reads clear when redirected
// - attention 3, 4, 6 wired straight through
module bsf_regs #(
   parameter int FLASH_FITTED = 1,
   parameter int WDOG_CYCLES  = `BSF_WDOG_PERIOD_MS * `BSF_CLK_KHZ
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [15:0] io_addr,
   input  wire logic        io_rd,
   input  wire logic        io_wr,
   input  wire bsf_pkg::bsf_byte_t io_wdata,
   output bsf_pkg::bsf_byte_t io_rdata,
   output logic             io_hit,
   output logic [8:0]       flash_page_address,
   output logic             flash_irq_gate,
   input  wire logic        serial_memory_data_line_i,
   output logic             serial_memory_data_line_o,
   output logic             serial_memory_data_line_oe,
   output logic             serial_memory_clock_o,
   output logic             serial_memory_clock_oe,
   output logic             user_led,
   input  wire logic        user_strap_a_jumper,
   input  wire logic        user_strap_b_jumper,
   input  wire logic        external_arbiter_selected,
   input  wire logic        arbitration_level_strap,
   input  wire logic        serial_one_redirect_strap,
   input  wire logic        video_redirect_strap,
   input  wire logic        reset_direction_strap,
   output logic             watchdog_active,
   output logic             bios_remap,
   output logic             system_reset_req,
   output logic             backplane_sysrst_o,
   output logic             backplane_sysrst_oe,
   input  wire logic        bus_cycle_active,
   input  wire logic        bus_slave_done,
   output logic             bus_cycle_terminate,
   output logic             backplane_tfrerr_o,
   output logic             backplane_tfrerr_oe,
   input  wire logic [7:0]  attention_req_n,
   input  wire logic        serial_one_irq,
   input  wire logic        serial_two_irq,
   input  wire logic        printer_irq,
   input  wire logic        mouse_irq,
   input  wire logic        flash_irq,
   output logic             nmi_req,
   output logic             irq3,
   output logic             irq4,
   output logic             irq5,
   output logic             irq7,
   output logic             irq9,
   output logic             irq10,
   output logic             irq11,
   output logic             irq12,
   output logic             irq15
);
   import bsf_pkg::*;

   localparam int TO_LONG  = `BSF_TO_LONG_US * `BSF_CLK_KHZ / 1000;
   localparam int TO_MID   = `BSF_TO_MID_US * `BSF_CLK_KHZ / 1000;
   localparam int TO_SHORT = `BSF_TO_SHORT_US * `BSF_CLK_KHZ / 1000;
   localparam int TO_W     = 10;
   localparam int WD_W     = $clog2(WDOG_CYCLES + 1);

   typedef struct packed {
      logic [3:0] flash_low;
      logic       flash_gate;
      logic [4:0] flash_high;
      logic       ser_data;
      logic       ser_clk;
      logic       led;
      logic       wd_active;
      logic       remap;
      bsf_seq_e   seq;
      logic       to_seen;
      logic       err_drive;
      logic       wd_reset;
      bsf_byte_t  bplane;
      bsf_byte_t  periph;
      bsf_byte_t  rdata;
      logic       hit;
   } bsf_regs_s;

   bsf_regs_s state;
   bsf_regs_s next_state;

   logic            sel_flash_low;
   logic            sel_flash_high;
   logic            sel_user;
   logic            sel_wdog;
   logic            sel_bplane;
   logic            sel_periph;
   logic            wr_wdog;
   logic            wd_kick;
   logic            wd_expired;
   logic            to_expired;
   logic            to_run;
   logic [TO_W-1:0] to_limit;
   logic [1:0]      period;
   logic [7:0]      atn;
   bsf_byte_t       user_view;
   bsf_byte_t       status_view;
   bsf_byte_t       periph_view;

   assign sel_flash_low  = (io_addr == `BSF_ADDR_FLASH_LOW) &&
                           (FLASH_FITTED != 0);
   assign sel_flash_high = (io_addr == `BSF_ADDR_FLASH_HIGH) &&
                           (FLASH_FITTED != 0);
   assign sel_user       = io_addr == `BSF_ADDR_USER;
   assign sel_wdog       = io_addr == `BSF_ADDR_WDOG;
   assign sel_bplane     = io_addr == `BSF_ADDR_BPLANE;
   assign sel_periph     = io_addr == `BSF_ADDR_PERIPH;
   assign wr_wdog        = io_wr && sel_wdog;
   assign atn            = ~attention_req_n;
   assign period = {state.bplane[`BSF_BIT_PERIOD_HIGH],
                    state.bplane[`BSF_BIT_PERIOD_LOW]};

   always_comb begin
      user_view = 8'h00;
      user_view[`BSF_BIT_SER_DATA] = state.ser_data;
      user_view[`BSF_BIT_SER_CLK]  = state.ser_clk;
      user_view[`BSF_BIT_STRAP_A]  = user_strap_a_jumper;
      user_view[`BSF_BIT_STRAP_B]  = user_strap_b_jumper;
      user_view[`BSF_BIT_LED]      = state.led;
   end

   always_comb begin
      status_view = 8'h00;
      status_view[`BSF_BIT_WD_ACTIVE]   = state.wd_active;
      status_view[`BSF_BIT_TO_SEEN]     = state.to_seen;
      status_view[`BSF_BIT_EXTERNAL_ARBITER_SELECTED]     = external_arbiter_selected;
      status_view[`BSF_BIT_ARBITRATION_LEVEL_STRAP]     = arbitration_level_strap;
      status_view[`BSF_BIT_SER1_REDIR]  = serial_one_redirect_strap;
      status_view[`BSF_BIT_VIDEO_REDIR] = video_redirect_strap;
   end

   always_comb begin
      periph_view = state.periph;
      if (serial_one_redirect_strap) begin
         periph_view[`BSF_BIT_SER1_IRQ] = 1'b0;
      end
   end

   always_comb begin
      case (period)
         2'b00:   to_limit = TO_W'(TO_LONG + 1);
         2'b01:   to_limit = TO_W'(TO_MID + 1);
         2'b10:   to_limit = TO_W'(TO_SHORT + 1);
         default: to_limit = '0;
      endcase
   end

   assign to_run = bus_cycle_active && !bus_slave_done && (period != 2'b11);

   bsf_interval_timer #(
      .WIDTH (TO_W)
   ) u_bus_timer (
      .clock   (clock),
      .resetn  (resetn),
      .ce      (ce),
      .run     (to_run),
      .restart (1'b0),
      .limit   (to_limit),
      .expired (to_expired)
   );

   bsf_interval_timer #(
      .WIDTH (WD_W)
   ) u_wdog_timer (
      .clock   (clock),
      .resetn  (resetn),
      .ce      (ce),
      .run     (state.wd_active && !state.wd_reset),
      .restart (wd_kick),
      .limit   (WD_W'(WDOG_CYCLES)),
      .expired (wd_expired)
   );

   // the key sequence only looks at writes to the watchdog register, so
   // accesses elsewhere between the two bytes do not break it
   always_comb begin
      wd_kick = 1'b0;
      if (wr_wdog) begin
         case (state.seq)
            BSF_SEQ_GOT33: wd_kick = io_wdata == `BSF_KEY_ENABLE;
            BSF_SEQ_GOT55: wd_kick = io_wdata == `BSF_KEY_KICK2;
            default:       wd_kick = 1'b0;
         endcase
      end
   end

   always_comb begin
      next_state = state;
      next_state.hit = io_rd && (sel_flash_low || sel_flash_high ||
                       sel_user || sel_wdog || sel_bplane || sel_periph);
      if (io_wr) begin
         if (sel_flash_low) begin
            next_state.flash_low  = io_wdata[3:0];
            next_state.flash_gate = io_wdata[`BSF_BIT_FLASH_IRQ];
         end
         if (sel_flash_high) begin
            next_state.flash_high = io_wdata[4:0];
         end
         if (sel_user) begin
            next_state.ser_data = io_wdata[`BSF_BIT_SER_DATA];
            next_state.ser_clk  = io_wdata[`BSF_BIT_SER_CLK];
            next_state.led      = io_wdata[`BSF_BIT_LED];
         end
         if (sel_bplane) begin
            next_state.bplane = io_wdata;
         end
         if (sel_periph) begin
            next_state.periph = {io_wdata[7], 4'h0, io_wdata[2:0]};
         end
      end
      if (wr_wdog) begin
         next_state.seq = BSF_SEQ_IDLE;
         case (state.seq)
            BSF_SEQ_GOT33: begin
               if (io_wdata == `BSF_KEY_ENABLE) begin
                  next_state.wd_active = 1'b1;
               end
               if (io_wdata == `BSF_KEY_REMAP) begin
                  next_state.remap = 1'b1;
               end
            end
            BSF_SEQ_GOT55: begin
               if (io_wdata == `BSF_KEY_DISENGAGE) begin
                  next_state.wd_active = 1'b0;
               end
            end
            default: begin
               next_state.seq = BSF_SEQ_IDLE;
            end
         endcase
         // a broken pair may itself start a new one
         if (io_wdata == `BSF_KEY_ARM && !wd_kick) begin
            next_state.seq = BSF_SEQ_GOT33;
         end else if (io_wdata == `BSF_KEY_KICK1) begin
            next_state.seq = BSF_SEQ_GOT55;
         end
      end
      if (wd_expired) begin
         next_state.wd_reset = 1'b1;
      end
      if (io_rd && sel_wdog) begin
         next_state.to_seen = 1'b0;
      end
      if (to_expired) begin
         next_state.to_seen = 1'b1;
      end
      if (!bus_cycle_active) begin
         next_state.err_drive = 1'b0;
      end else if (to_expired && state.bplane[`BSF_BIT_TO_BCAST]) begin
         next_state.err_drive = 1'b1;
      end
      if (io_rd) begin
         if (sel_flash_low) begin
            next_state.rdata = {3'b000, state.flash_gate, state.flash_low};
         end else if (sel_flash_high) begin
            next_state.rdata = {3'b000, state.flash_high};
         end else if (sel_user) begin
            next_state.rdata = user_view;
         end else if (sel_wdog) begin
            next_state.rdata = status_view;
         end else if (sel_bplane) begin
            next_state.rdata = state.bplane;
         end else if (sel_periph) begin
            next_state.rdata = periph_view;
         end else begin
            next_state.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state            <= '0;
         state.flash_low  <= `BSF_RST_FLASH_LOW;
         state.flash_high <= `BSF_RST_FLASH_HIGH;
         state.seq        <= BSF_SEQ_IDLE;
         state.bplane     <= `BSF_RST_BPLANE;
         state.periph     <= `BSF_RST_PERIPH;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign io_rdata           = state.rdata;
   assign io_hit             = state.hit;
   assign flash_page_address = {state.flash_high, state.flash_low};
   assign flash_irq_gate     = state.flash_gate;

   assign serial_memory_data_line_o  = 1'b0;
   assign serial_memory_data_line_oe = state.ser_data;
   assign serial_memory_clock_o      = 1'b0;
   assign serial_memory_clock_oe     = state.ser_clk;
   assign user_led                   = state.led;

   assign watchdog_active  = state.wd_active;
   assign bios_remap       = state.remap;
   // held until the resulting system reset clears the bank
   assign system_reset_req = state.wd_reset;
   assign backplane_sysrst_o  = 1'b0;
   assign backplane_sysrst_oe = state.wd_reset && reset_direction_strap;

   assign bus_cycle_terminate = to_expired;
   assign backplane_tfrerr_o  = 1'b0;
   assign backplane_tfrerr_oe = state.err_drive;

   assign nmi_req = (state.bplane[`BSF_BIT_ATN0] && atn[0]) ||
                    (state.periph[`BSF_BIT_SER2_NMI] && serial_two_irq);
   assign irq3  = (state.bplane[`BSF_BIT_ATN1] && atn[1] &&
                   !serial_one_redirect_strap) ||
                  (state.periph[`BSF_BIT_SER2_IRQ] && serial_two_irq);
   assign irq4  = (state.bplane[`BSF_BIT_ATN2] && atn[2]) ||
                  (periph_view[`BSF_BIT_SER1_IRQ] && serial_one_irq);
   assign irq7  = (state.bplane[`BSF_BIT_ATN5] && atn[5]) ||
                  (state.periph[`BSF_BIT_PRN_IRQ] && printer_irq);
   assign irq12 = state.bplane[`BSF_BIT_ATN7] ? atn[7] : mouse_irq;
   assign irq5  = atn[3];
   assign irq10 = atn[4];
   assign irq11 = atn[6];
   assign irq9  = state.to_seen;
   assign irq15 = state.flash_gate && flash_irq;
endmodule : bsf_regs

// *** core/bsf_cfg.svh ***
// offsets, field positions, reset values and timing figures
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH
`define BSF_ADDR_FLASH_LOW   16'h0258
`define BSF_ADDR_FLASH_HIGH  16'h0259
`define BSF_ADDR_USER        16'h025C
`define BSF_ADDR_WDOG        16'h025D
`define BSF_ADDR_BPLANE      16'h025E
`define BSF_ADDR_PERIPH      16'h025F
`define BSF_RST_FLASH_LOW    4'h0
`define BSF_RST_FLASH_HIGH   5'h00
`define BSF_RST_BPLANE       8'h00
`define BSF_RST_PERIPH       8'h07
`define BSF_BIT_FLASH_IRQ    4
`define BSF_BIT_SER_DATA     0
`define BSF_BIT_SER_CLK      1
`define BSF_BIT_STRAP_A      4
`define BSF_BIT_STRAP_B      5
`define BSF_BIT_LED          7
`define BSF_BIT_WD_ACTIVE    0
`define BSF_BIT_TO_SEEN      1
`define BSF_BIT_EXTERNAL_ARBITER_SELECTED      4
`define BSF_BIT_ARBITRATION_LEVEL_STRAP      5
`define BSF_BIT_SER1_REDIR   6
`define BSF_BIT_VIDEO_REDIR  7
`define BSF_BIT_ATN0         0
`define BSF_BIT_ATN1         1
`define BSF_BIT_ATN2         2
`define BSF_BIT_ATN5         3
`define BSF_BIT_ATN7         4
`define BSF_BIT_TO_BCAST     5
`define BSF_BIT_PERIOD_LOW   6
`define BSF_BIT_PERIOD_HIGH  7
`define BSF_BIT_SER1_IRQ     0
`define BSF_BIT_SER2_IRQ     1
`define BSF_BIT_PRN_IRQ      2
`define BSF_BIT_SER2_NMI     7
`define BSF_KEY_ARM          8'h33
`define BSF_KEY_ENABLE       8'hCC
`define BSF_KEY_REMAP        8'h99
`define BSF_KEY_KICK1        8'h55
`define BSF_KEY_KICK2        8'hAA
`define BSF_KEY_DISENGAGE    8'h66
`define BSF_CLK_KHZ          20000
`define BSF_WDOG_PERIOD_MS   1000
`define BSF_TO_LONG_US       16
`define BSF_TO_MID_US        8
`define BSF_TO_SHORT_US      4
`endif

// *** core/bsf_pkg.sv ***
// types shared by the board special function register bank
package bsf_pkg;
   typedef enum logic [1:0] {
      BSF_SEQ_IDLE  = 2'b00,
      BSF_SEQ_GOT33 = 2'b01,
      BSF_SEQ_GOT55 = 2'b10
   } bsf_seq_e;

   typedef logic [7:0] bsf_byte_t;
endpackage : bsf_pkg

// *** core/bsf_interval_timer.sv ***
// cycle counter that reports once when it reaches its limit
`timescale 1ns/1ps
module bsf_interval_timer #(
   parameter int WIDTH = 25
) (
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire logic             ce,
   input  wire logic             run,
   input  wire logic             restart,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  expired
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             hit;
   } bsf_timer_s;

   bsf_timer_s state;
   bsf_timer_s next_state;

   always_comb begin
      next_state = state;
      next_state.hit = 1'b0;
      if (!run || restart) begin
         next_state.count = '0;
      end else if (state.count != limit) begin
         next_state.count = state.count + 1'b1;
         // fires on the step onto the limit only, so one pulse per run
         next_state.hit = (state.count + 1'b1) == limit;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign expired = state.hit;
endmodule : bsf_interval_timer

// *** test/bsf_regs_properties.sv ***
// port-level assertions for the special function register bank
`timescale 1ns/1ps
module bsf_regs_properties (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        ce,
   input wire logic [15:0] io_addr,
   input wire logic        io_rd,
   input wire logic        io_wr,
   input wire logic [7:0]  io_wdata,
   input wire logic [7:0]  io_rdata,
   input wire logic        io_hit,
   input wire logic        user_led,
   input wire logic        serial_memory_data_line_oe,
   input wire logic        watchdog_active,
   input wire logic        bios_remap,
   input wire logic        system_reset_req,
   input wire logic        reset_direction_strap,
   input wire logic        backplane_sysrst_oe,
   input wire logic        bus_cycle_active,
   input wire logic        bus_cycle_terminate,
   input wire logic        backplane_tfrerr_oe,
   input wire logic [7:0]  attention_req_n,
   input wire logic        irq5,
   input wire logic        irq9,
   input wire logic        irq10,
   input wire logic        irq11
);
   import bsf_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!resetn);
   sequence wd_key(bsf_byte_t k);
      ce && io_wr && io_addr == 16'h025D && io_wdata == k;
   endsequence
   // the pair must not be split by another watchdog write
   sequence wd_pair(bsf_byte_t a, bsf_byte_t b);
      wd_key(a) ##1 !(io_wr && io_addr == 16'h025D) ##1 wd_key(b);
   endsequence
   sequence status_quiet;
      !(io_rd && io_addr == 16'h025D);
   endsequence
   a_user_write: assert property (
      ce && io_wr && io_addr == 16'h025C |=> {user_led,
      serial_memory_data_line_oe} == {$past(io_wdata[7]), $past(io_wdata[0])})
      else $error("user register write not reflected");
   a_read_hit: assert property (
      ce && io_rd && io_addr[15:2] == 14'h0097 |=> io_hit)
      else $error("mapped read gave no hit");
   a_status_clear: assert property (
      ce && io_rd && io_addr == 16'h025D && !bus_cycle_active |=> !irq9)
      else $error("status read left time-out flag set");
   a_expiry_flag: assert property (
      bus_cycle_terminate ##1 status_quiet [*2] |-> irq9)
      else $error("time-out flag not raised");
   a_terminate_cause: assert property (
      bus_cycle_terminate |-> $past(bus_cycle_active) ##1 !bus_cycle_terminate)
      else $error("terminate without transfer or too long");
   a_tfrerr_cause: assert property (
      $rose(backplane_tfrerr_oe) |-> $past(bus_cycle_terminate))
      else $error("transfer error without time-out");
   a_sysrst_drive: assert property (
      backplane_sysrst_oe == (system_reset_req && reset_direction_strap))
      else $error("backplane reset drive wrong");
   a_direct_lines: assert property (
      {irq5, irq10, irq11} ==
      ~{attention_req_n[3], attention_req_n[4], attention_req_n[6]})
      else $error("direct attention line wrong");
   a_wd_enable: assert property (
      wd_pair(8'h33, 8'hCC) |=> watchdog_active)
      else $error("watchdog not enabled");
   a_wd_disengage: assert property (
      wd_pair(8'h55, 8'h66) |=> !watchdog_active)
      else $error("watchdog not disengaged");
   a_rom_remap: assert property (
      wd_pair(8'h33, 8'h99) |=> bios_remap)
      else $error("boot rom not remapped");
endmodule : bsf_regs_properties
bind bsf_regs bsf_regs_properties u_props (.clock, .resetn, .ce, .io_addr,
   .io_rd, .io_wr, .io_wdata, .io_rdata, .io_hit, .user_led,
   .serial_memory_data_line_oe, .watchdog_active, .bios_remap,
   .system_reset_req, .reset_direction_strap, .backplane_sysrst_oe,
   .bus_cycle_active, .bus_cycle_terminate, .backplane_tfrerr_oe,
   .attention_req_n, .irq5, .irq9, .irq10, .irq11);

// *** test/bsf_backplane_slave.sv ***
// backplane slave model answering a transfer after a set delay
`timescale 1ns/1ps
module bsf_backplane_slave (
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       start,
   input  wire logic [9:0] answer_delay,
   input  wire logic       bus_cycle_terminate,
   output logic            bus_cycle_active,
   output logic            bus_slave_done
);
   logic [9:0] waited;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus_cycle_active <= 1'b0;
         bus_slave_done <= 1'b0;
         waited <= '0;
      end else if (!bus_cycle_active) begin
         bus_cycle_active <= start;
         waited <= 10'h001;
      end else if (bus_slave_done || bus_cycle_terminate) begin
         bus_cycle_active <= 1'b0;
         bus_slave_done <= 1'b0;
      end else begin
         // zero delay stands for an empty address that never answers
         bus_slave_done <= answer_delay != 0 && waited == answer_delay;
         waited <= waited + 10'h001;
      end
   end
endmodule : bsf_backplane_slave

// *** test/bsf_regs_bench.sv ***
// self-checking bench for the special function register bank
`timescale 1ns/1ps
module bsf_regs_bench;
   import bsf_pkg::*;
   localparam logic [7:0] ROUTE [8] = '{8'h80, 8'h40, 8'h20, 8'h10,
                                        8'h04, 8'h08, 8'h02, 8'h01};
   localparam int LIMIT [3] = '{320, 160, 80};
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic [15:0] io_addr = '0;
   logic        io_rd = 1'b0;
   logic        io_wr = 1'b0;
   bsf_byte_t   io_wdata = '0;
   bsf_byte_t   io_rdata;
   logic [6:0]  straps = 7'h65;
   logic [4:0]  srcs = '0;
   logic [7:0]  attn_n = 8'hFF;
   logic [9:0]  lines;
   logic [8:0]  flash_page_address;
   logic        start = 1'b0;
   logic [9:0]  delay = '0;
   logic        io_hit, flash_irq_gate, sd_oe, sc_oe, user_led, wd_on;
   logic        bios_remap, sys_req, sysrst_oe, bus_cycle_active;
   logic        bus_slave_done, bus_cycle_terminate, tfrerr_oe;
   int          bad_count = 0;
   int          total_checks = 0;
   int          n;
   always #25 clock = ~clock;
   bsf_regs #(.WDOG_CYCLES(200)) u_dut (.clock, .resetn, .ce(1'b1),
      .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_hit,
      .flash_page_address, .flash_irq_gate,
      .serial_memory_data_line_i(!sd_oe), .serial_memory_data_line_o(),
      .serial_memory_data_line_oe(sd_oe), .serial_memory_clock_o(),
      .serial_memory_clock_oe(sc_oe), .user_led,
      .user_strap_a_jumper(straps[0]), .user_strap_b_jumper(straps[1]),
      .external_arbiter_selected(straps[2]),
      .arbitration_level_strap(straps[3]),
      .serial_one_redirect_strap(straps[4]),
      .video_redirect_strap(straps[5]), .reset_direction_strap(straps[6]),
      .watchdog_active(wd_on), .bios_remap, .system_reset_req(sys_req),
      .backplane_sysrst_o(), .backplane_sysrst_oe(sysrst_oe),
      .bus_cycle_active, .bus_slave_done, .bus_cycle_terminate,
      .backplane_tfrerr_o(), .backplane_tfrerr_oe(tfrerr_oe),
      .attention_req_n(attn_n), .serial_one_irq(srcs[0]),
      .serial_two_irq(srcs[1]), .printer_irq(srcs[2]), .mouse_irq(srcs[3]),
      .flash_irq(srcs[4]), .nmi_req(lines[9]), .irq3(lines[8]),
      .irq4(lines[7]), .irq5(lines[6]), .irq7(lines[5]), .irq9(lines[1]),
      .irq10(lines[4]), .irq11(lines[3]), .irq12(lines[2]),
      .irq15(lines[0]));
   bsf_backplane_slave u_slave (.clock, .resetn, .start,
      .answer_delay(delay), .bus_cycle_terminate, .bus_cycle_active,
      .bus_slave_done);
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : tick
   task automatic wr(input logic [15:0] a, input bsf_byte_t d);
      tick(1);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      tick(1);
      io_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input bsf_byte_t e);
      tick(1);
      io_addr = a;
      io_rd = 1'b1;
      tick(1);
      io_rd = 1'b0;
      check(io_rdata, e);
      check(io_hit, a[15:3] == 13'h004B && a[2:1] != 2'b01);
   endtask : rd
   // bounded wait for a terminate; k equals the bound when none came
   task automatic run_cycle(input logic [9:0] d, output int k);
      delay = d;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      k = 0;
      while (bus_cycle_terminate !== 1'b1 && k < 400) begin
         tick(1);
         k++;
      end
   endtask : run_cycle
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   initial begin
      tick(8);
      resetn = 1'b1;
      rd(16'h025C, 8'h10);
      rd(16'h025D, 8'h90);
      rd(16'h025E, 8'h00);
      rd(16'h025F, 8'h07);
      rd(16'h0258, 8'h00);
      rd(16'h0259, 8'h00);
      rd(16'h025A, 8'h00);
      wr(16'h025C, 8'hFF);
      rd(16'h025C, 8'h93);
      check({user_led, sd_oe, sc_oe}, 3'b111);
      wr(16'h025C, 8'h00);
      check({user_led, sd_oe, sc_oe}, 3'b000);
      wr(16'h0259, 8'hFF);
      wr(16'h0258, 8'hFF);
      rd(16'h0259, 8'h1F);
      check({flash_irq_gate, flash_page_address}, 10'h3FF);
      srcs = 5'h10;
      tick(1);
      check(lines[0], 1'b1);
      wr(16'h0258, 8'h0F);
      check(lines[0], 1'b0);
      srcs = 5'h00;
      $display("test registers done");
      wr(16'h025F, 8'h00);
      for (int p = 0; p < 2; p++) begin
         wr(16'h025E, p ? 8'h00 : 8'h1F);
         for (int i = 0; i < 8; i++) begin
            attn_n = ~(8'h01 << i);
            tick(1);
            check(lines[9:2], ROUTE[i] & (p ? 8'h16 : 8'hFF));
         end
      end
      straps[4] = 1'b1;
      wr(16'h025E, 8'h02);
      attn_n = 8'hFD;
      tick(1);
      check(lines[8], 1'b0);
      wr(16'h025F, 8'h01);
      rd(16'h025F, 8'h00);
      straps[4] = 1'b0;
      attn_n = 8'hFF;
      srcs = 5'h08;
      wr(16'h025E, 8'h10);
      check(lines[2], 1'b0);
      srcs = 5'h07;
      wr(16'h025F, 8'h87);
      check({lines[9:7], lines[5]}, 4'hF);
      wr(16'h025F, 8'h00);
      check({lines[9:7], lines[5]}, 4'h0);
      srcs = 5'h00;
      $display("test routing done");
      for (int p = 0; p < 3; p++) begin
         wr(16'h025E, {p[1:0], 6'h20});
         run_cycle(10'h000, n);
         check(n >= LIMIT[p] && n <= LIMIT[p] + 4, 1'b1);
         tick(1);
         check({tfrerr_oe, lines[1]}, 2'b11);
         tick(3);
         check(tfrerr_oe, 1'b0);
         rd(16'h025D, 8'h92);
         check(lines[1], 1'b0);
      end
      wr(16'h025E, 8'hC0);
      run_cycle(10'h1F4, n);
      check(n, 400);
      // let the slow slave finish before the next transfer
      tick(110);
      wr(16'h025E, 8'h80);
      run_cycle(10'h005, n);
      check(n, 400);
      $display("test time-out done");
      wr(16'h025D, 8'h33);
      wr(16'h025D, 8'hCC);
      rd(16'h025D, 8'h91);
      repeat (3) begin
         tick(150);
         wr(16'h025D, 8'h55);
         wr(16'h025D, 8'hAA);
      end
      check(sys_req, 1'b0);
      wr(16'h025D, 8'h55);
      wr(16'h025D, 8'h66);
      tick(250);
      check({wd_on, sys_req}, 2'b00);
      wr(16'h025D, 8'h33);
      wr(16'h025D, 8'h99);
      check(bios_remap, 1'b1);
      wr(16'h025D, 8'h33);
      wr(16'h025D, 8'hCC);
      n = 0;
      while (sys_req !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      check(n >= 195 && n <= 201, 1'b1);
      check(sysrst_oe, 1'b1);
      $display("test watchdog done");
      test_done();
   end
endmodule : bsf_regs_bench
